/* File: dv/ood_fetch_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// fetch side, one opcode per call
module ood_fetch_model (
  input wire pclk,
  output logic op_valid,
  output logic [7:0] op_byte,
  output logic [7:0] opnd1,
  output logic [7:0] opnd2,
  output logic [12:0] next_pc
);
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
    opnd1 = 8'h00;
    opnd2 = 8'h00;
    next_pc = 13'h0000;
  end
  task automatic issue(input logic [7:0] b, input logic [7:0] o1, input logic [12:0] pc);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_byte <= b;
    opnd1 <= o1;
    opnd2 <= ~o1;
    next_pc <= pc;
    @(posedge pclk);
    // bytes mean nothing without the strobe, so show junk on op_byte, opnd1 and next_pc
    op_valid <= 1'b0;
    op_byte <= ~b;
    opnd1 <= ~o1;
    next_pc <= ~pc;
  endtask
endmodule // ood_fetch_model
`default_nettype wire

/* File: dv/ood_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ood_map.vh"
// ====
// decoder port checks
module ood_props #(
  parameter ADDR_W = 13
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire op_valid,
  input wire [7:0] op_byte,
  input wire [7:0] opnd1,
  input wire [ADDR_W-1:0] next_pc,
  input wire dec_valid_q,
  input wire [4:0] dec_op_q,
  input wire [2:0] dec_form_q,
  input wire dec_undef_q,
  input wire branch_taken_q,
  input wire [ADDR_W-1:0] branch_target_q
);
  logic [7:0] ob_q;
  logic [7:0] o1_q;
  logic [ADDR_W-1:0] pc_q;
  // inputs one cycle back, the cause of each decode result
  always @(posedge pclk) begin
    ob_q <= op_byte;
    o1_q <= opnd1;
    pc_q <= next_pc;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_DEC_CAUSE: assert property (dec_valid_q |-> $past(op_valid))
    else $error("decode without request");
  AST_ARITH: assert property (dec_valid_q && ob_q[3:0] inside {[2:6]}
    && (!ob_q[7] || ob_q[7:4] inside {4'ha, 4'hb}) |-> dec_form_q == ob_q[2:0] - 3'd1
    && dec_op_q == (ob_q[7] ? ob_q[7:4] - 4'd1 : ob_q[7:4] + 4'd1))
    else $error("arith decode wrong");
  AST_CTRL_F: assert property (dec_valid_q && ob_q[3:0] == 4'hf && ob_q[7:4] >= 4'h6
    |-> dec_op_q == {1'b0, ob_q[7:4]} + 5'd5)
    else $error("control decode wrong");
  AST_UNDEF: assert property (dec_valid_q && dec_undef_q
    |-> dec_op_q == `OOD_OP_UNDEF && dec_form_q == `OOD_FM_NONE)
    else $error("undefined slot not idle");
  AST_REL: assert property (dec_valid_q && ob_q[3:0] == 4'hb
    |-> branch_target_q == pc_q + {{(ADDR_W-8){o1_q[7]}}, o1_q})
    else $error("relative target wrong");
  AST_COND: assert property (dec_valid_q && ob_q[3:0] == 4'hb && ob_q[6:4] == 3'h0
    |-> branch_taken_q == ob_q[7])
    else $error("fixed condition wrong");
endmodule // ood_props
bind ood_decoder ood_props #(.ADDR_W(ADDR_W)) i_ood_props (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .op_valid, .op_byte, .opnd1, .next_pc, .dec_valid_q,
  .dec_op_q, .dec_form_q, .dec_undef_q, .branch_taken_q, .branch_target_q);
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ood_map.vh"
// ====
// decoder bench
module tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] r;
  logic e;
  int err_count;
  int compares;
  wire [31:0] prdata;
  wire pready, pslverr, op_valid, dec_valid_q, dec_undef_q, branch_taken_q;
  wire dec_range_err_q, dst_ind_q, src_ind_q;
  wire [7:0] op_byte, opnd1, opnd2, dst_addr_q, src_addr_q;
  wire [12:0] next_pc, branch_target_q;
  wire [4:0] dec_op_q;
  wire [2:0] dec_form_q;
  ood_fetch_model i_ood_fetch_model (.pclk, .op_valid, .op_byte, .opnd1, .opnd2, .next_pc);
  ood_decoder i_ood_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .op_valid, .op_byte, .opnd1, .opnd2, .next_pc, .dec_valid_q,
    .dec_op_q, .dec_form_q, .dec_undef_q, .dec_range_err_q, .dst_addr_q, .src_addr_q,
    .dst_ind_q, .src_ind_q, .branch_taken_q, .branch_target_q);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task close_out;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic [9:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task dec(input logic [7:0] b, input logic [7:0] o1, input logic [12:0] pc);
    i_ood_fetch_model.issue(b, o1, pc);
    #1;
  endtask
  task t_regs;
    apb(`OOD_FLAGS_OFF, 1'b0, 0);
    chk(r, `OOD_FLAGS_RST);
    apb(10'h040, 1'b0, 32'h0000_0000);
    chk({r[30:0], e}, 32'h0000_0001);
    dec(8'h02, 8'h12, 0);
    // decode stays off until enabled
    chk(dec_valid_q, 0);
    apb(`OOD_CTRL_OFF, 1'b1, 1);
  endtask
  task t_arith;
    logic [3:0] up [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11};
    for (int u = 0; u < 10; u++)
      for (int l = 2; l < 7; l++) begin
        dec({up[u], 4'(l)}, 8'h12, 0);
        chk({dec_valid_q, dec_op_q, dec_form_q}, {1'b1, 5'(`OOD_OP_ADD + u), 3'(l - 1)});
      end
  endtask
  task t_ctrl;
    for (int u = 6; u < 16; u++) begin
      dec({4'(u), 4'hf}, 0, 0);
      chk({dec_undef_q, dec_op_q}, {1'b0, 5'(`OOD_OP_IDLE + u - 6)});
    end
    dec(8'h80, 0, 0);
    chk({dec_undef_q, dec_op_q, dec_form_q}, {1'b1, `OOD_OP_UNDEF, `OOD_FM_NONE});
    dec(8'h0f, 0, 0);
    chk({dec_undef_q, dec_op_q}, {1'b1, `OOD_OP_UNDEF});
  endtask
  task t_branch;
    dec(8'h8b, 8'h80, 13'h0100);
    chk({branch_taken_q, branch_target_q}, {1'b1, 13'h0080});
    dec(8'h0b, 8'h7f, 13'h0010);
    chk({branch_taken_q, branch_target_q}, {1'b0, 13'h008f});
    apb(`OOD_FLAGS_OFF, 1'b1, 32'h0000_0080);
    dec(8'h7b, 0, 0);
    chk(branch_taken_q, 1);
    dec(8'hfb, 0, 0);
    chk(branch_taken_q, 0);
    dec(8'h8d, 8'h1f, 13'h0000);
    chk({branch_taken_q, dec_range_err_q, branch_target_q}, {1'b1, 1'b0, 13'h1fe0});
    dec(8'h0d, 8'h20, 13'h0000);
    chk({branch_taken_q, dec_range_err_q, branch_target_q}, {1'b0, 1'b1, 13'h00df});
  endtask
  task t_opnd;
    logic [11:0] tbl [6] = '{12'h203, 12'h2fe, 12'h305, 12'h300, 12'h00f, 12'h71f};
    logic ok [6] = '{0, 1, 0, 1, 1, 0};
    for (int i = 0; i < 6; i++) begin
      apb(`OOD_OPND_OFF, 1'b1, {20'h0_0000, tbl[i][11:8], tbl[i][7:0]});
      apb(`OOD_STAT_OFF, 1'b0, 32'h0000_0000);
      chk(r[8], ok[i]);
    end
  endtask
  task t_forms;
    dec(8'h02, 8'h12, 13'h0000);
    chk({dst_addr_q, src_addr_q, dst_ind_q, src_ind_q}, {8'hc1, 8'hc2, 2'b00});
    dec(8'h13, 8'h3f, 13'h0000);
    chk({dst_addr_q, src_addr_q, dst_ind_q, src_ind_q}, {8'hc3, 8'hcf, 2'b01});
    dec(8'h24, 8'hc5, 13'h0000);
    chk({dst_addr_q, src_addr_q, dst_ind_q, src_ind_q}, {8'h3a, 8'hc5, 2'b00});
    dec(8'h35, 8'h40, 13'h0000);
    chk({dst_addr_q, src_addr_q, dst_ind_q, src_ind_q}, {8'hbf, 8'h40, 2'b01});
    dec(8'h46, 8'h33, 13'h0000);
    chk({dst_addr_q, src_addr_q, dst_ind_q, src_ind_q}, {8'h33, 8'hcc, 2'b00});
  endtask
  task t_index;
    apb(`OOD_CTRL_OFF, 1'b1, 32'h0000_0201);
    apb(`OOD_OPND_OFF, 1'b1, 32'h0000_0480);
    apb(`OOD_RESULT_OFF, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_1f80);
    // two blank slots were decoded so far
    apb(`OOD_STAT_OFF, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_0102);
    apb(`OOD_CTRL_OFF, 1'b1, 32'h0000_0301);
    apb(`OOD_STAT_OFF, 1'b0, 32'h0000_0000);
    chk(r[8], 1'b0);
    apb(`OOD_CTRL_OFF, 1'b1, 32'h0000_f801);
    apb(`OOD_OPND_OFF, 1'b1, 32'h0000_05ff);
    apb(`OOD_RESULT_OFF, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_1fff);
    apb(`OOD_STAT_OFF, 1'b0, 32'h0000_0000);
    chk(r[8], 1'b1);
  endtask
  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({dec_op_q, dec_form_q, branch_target_q, dst_addr_q}, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(`OOD_CTRL_OFF, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    dec(8'h02, 8'h12, 13'h0000);
    chk(dec_valid_q, 1'b0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_arith;
    t_forms;
    t_ctrl;
    t_branch;
    t_opnd;
    t_index;
    t_reset;
    close_out;
  end
  initial begin
    #50000;
    err_count++;
    close_out;
  end
endmodule // tb
`default_nettype wire

/* File: logic/ood_cond_eval.v */
`timescale 1ns/100ps
`default_nettype none
`include "ood_map.vh"
// condition evaluator for conditional jumps
module ood_cond_eval (
  input wire [3:0] cond,
  input wire [7:0] flags,
  output reg taken
);
  reg c;
  reg z;
  reg s;
  reg v;
  reg base;
  always @* begin
    c = flags[`OOD_FLAG_C];
    z = flags[`OOD_FLAG_Z];
    s = flags[`OOD_FLAG_S];
    v = flags[`OOD_FLAG_V];
    // high bit of the code inverts the low three bits' test
    case (cond[2:0])
      3'h0: base = 1'b0;
      3'h1: base = s ^ v;
      3'h2: base = z | (s ^ v);
      3'h3: base = c | z;
      3'h4: base = v;
      3'h5: base = s;
      3'h6: base = z;
      3'h7: base = c;
      default: base = 1'b0;
    endcase
    taken = base ^ cond[3];
  end
endmodule // ood_cond_eval
`default_nettype wire

/* File: logic/ood_decoder.v */
// Behaviour
// - indirect working register selects R0 to R15
// - register operand: 8-bit address or working number
// - register pair must be even address
// - indirect pair also even only
// - short index: signed -128..127 with even pair
// - long index: 13-bit offset with even pair
// - relative offset added to next instruction address
// - nibbles 2-6 decode arithmetic/logic and operand form
// - nibble F decodes control operations in order
// - condition field tested against C Z S V
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ood_map.vh"
module ood_decoder #(
  parameter ADDR_W = 13
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire op_valid,
  input wire [7:0] op_byte,
  input wire [7:0] opnd1,
  input wire [7:0] opnd2,
  input wire [ADDR_W-1:0] next_pc,
  output reg dec_valid_q,
  output reg [4:0] dec_op_q,
  output reg [2:0] dec_form_q,
  output reg dec_undef_q,
  output reg dec_range_err_q,
  output reg [7:0] dst_addr_q,
  output reg [7:0] src_addr_q,
  output reg dst_ind_q,
  output reg src_ind_q,
  output reg branch_taken_q,
  output reg [ADDR_W-1:0] branch_target_q
);
  // ==========================================================
  // registers
  // ==========================================================
  reg [7:0] flags_q;
  reg [7:0] ctrl_q;
  reg [7:0] wpage_q;
  reg [2:0] ck_kind_q;
  reg [7:0] ck_val_q;
  reg ck_ok_q;
  reg [ADDR_W-1:0] idx_addr_q;
  reg [7:0] undef_cnt_q;

  // ==========================================================
  // operand range checker, driven over apb for software probing
  // ==========================================================
  reg ck_ok_d;
  reg [ADDR_W-1:0] idx_addr_d;
  always @* begin
    ck_ok_d = 1'b1;
    idx_addr_d = {ADDR_W{1'b0}};
    case (ck_kind_q)
      `OOD_CK_WREG: ck_ok_d = (ck_val_q[7:4] == 4'h0);
      `OOD_CK_IWREG: ck_ok_d = (ck_val_q[7:4] == 4'h0);
      `OOD_CK_GREG: ck_ok_d = 1'b1;
      `OOD_CK_PAIR: ck_ok_d = ~ck_val_q[0];
      `OOD_CK_IPAIR: ck_ok_d = ~ck_val_q[0];
      `OOD_CK_SIDX: begin
        // pair number in wpage low nibble, displacement sign extended
        ck_ok_d = ~wpage_q[0];
        idx_addr_d = {{(ADDR_W-8){ck_val_q[7]}}, ck_val_q};
      end
      `OOD_CK_LIDX: begin
        ck_ok_d = ~wpage_q[0];
        idx_addr_d = {wpage_q[7:3], ck_val_q};
      end
      `OOD_CK_REL: begin
        ck_ok_d = 1'b1;
        idx_addr_d = next_pc + {{(ADDR_W-8){ck_val_q[7]}}, ck_val_q};
      end
      default: ck_ok_d = 1'b0;
    endcase
  end

  // ==========================================================
  // opcode decode
  // ==========================================================
  reg [4:0] op_d;
  reg [2:0] form_d;
  reg undef_d;
  reg err_d;
  reg [7:0] dst_d;
  reg [7:0] src_d;
  reg dind_d;
  reg sind_d;
  reg br_d;
  reg [ADDR_W-1:0] tgt_d;
  wire [3:0] hi = op_byte[7:4];
  wire [3:0] lo = op_byte[3:0];
  wire cond_true;

  ood_cond_eval u_cond (
    .cond(hi),
    .flags(flags_q),
    .taken(cond_true)
  );

  // working register number to full address via the fixed tag nibble
  function [7:0] wreg;
    input [3:0] n;
    begin
      wreg = {`OOD_WREG_TAG, n};
    end
  endfunction

  // general operand: upper nibble tag marks a working register
  function [7:0] greg;
    input [7:0] v;
    begin
      greg = (v[7:4] == `OOD_WREG_TAG) ? wreg(v[3:0]) : v;
    end
  endfunction

  always @* begin
    op_d = `OOD_OP_UNDEF;
    form_d = `OOD_FM_NONE;
    undef_d = 1'b1;
    err_d = 1'b0;
    dst_d = 8'h00;
    src_d = 8'h00;
    dind_d = 1'b0;
    sind_d = 1'b0;
    br_d = 1'b0;
    tgt_d = next_pc;
    if (lo >= 4'h2 && lo <= 4'h6) begin
      undef_d = 1'b0;
      case (hi)
        4'h0: op_d = `OOD_OP_ADD;
        4'h1: op_d = `OOD_OP_ADC;
        4'h2: op_d = `OOD_OP_SUB;
        4'h3: op_d = `OOD_OP_SUBTRACT_BORROW;
        4'h4: op_d = `OOD_OP_OR;
        4'h5: op_d = `OOD_OP_AND;
        4'h6: op_d = `OOD_OP_TEST_COMPLEMENT_MASK;
        4'h7: op_d = `OOD_OP_TEST_MASK;
        4'ha: op_d = `OOD_OP_COMPARE;
        4'hb: op_d = `OOD_OP_XOR;
        default: undef_d = 1'b1;
      endcase
      if (!undef_d) begin
        case (lo)
          4'h2: begin
            form_d = `OOD_FM_RR;
            dst_d = wreg(opnd1[7:4]);
            src_d = wreg(opnd1[3:0]);
          end
          4'h3: begin
            form_d = `OOD_FM_RIR;
            dst_d = wreg(opnd1[7:4]);
            src_d = wreg(opnd1[3:0]);
            sind_d = 1'b1;
          end
          4'h4: begin
            form_d = `OOD_FM_GG;
            src_d = greg(opnd1);
            dst_d = greg(opnd2);
          end
          4'h5: begin
            form_d = `OOD_FM_GIG;
            src_d = greg(opnd1);
            dst_d = greg(opnd2);
            sind_d = 1'b1;
          end
          4'h6: begin
            form_d = `OOD_FM_GIM;
            dst_d = greg(opnd1);
            src_d = opnd2;
          end
          default: form_d = `OOD_FM_NONE;
        endcase
      end
    end else if (lo == 4'hf) begin
      undef_d = 1'b0;
      case (hi)
        4'h6: op_d = `OOD_OP_IDLE;
        4'h7: op_d = `OOD_OP_STOP;
        4'h8: op_d = `OOD_OP_DISABLE_INTERRUPTS;
        4'h9: op_d = `OOD_OP_ENABLE_INTERRUPTS;
        4'ha: op_d = `OOD_OP_RET;
        4'hb: op_d = `OOD_OP_INTERRUPT_RETURN;
        4'hc: op_d = `OOD_OP_RESET_CARRY;
        4'hd: op_d = `OOD_OP_SET_CARRY;
        4'he: op_d = `OOD_OP_COMPLEMENT_CARRY;
        4'hf: op_d = `OOD_OP_NOP;
        default: undef_d = 1'b1;
      endcase
    end else if (lo == 4'hb) begin
      undef_d = 1'b0;
      op_d = `OOD_OP_JR;
      form_d = `OOD_FM_REL;
      br_d = cond_true;
      tgt_d = next_pc + {{(ADDR_W-8){opnd1[7]}}, opnd1};
    end else if (lo == 4'hd) begin
      undef_d = 1'b0;
      op_d = `OOD_OP_JP;
      form_d = `OOD_FM_DA;
      br_d = cond_true;
      tgt_d = {opnd1[ADDR_W-9:0], opnd2};
      // direct target bits above the program space are dropped from the target and flagged
      err_d = |opnd1[7:ADDR_W-8];
    end
    if (undef_d) begin
      op_d = `OOD_OP_UNDEF;
      form_d = `OOD_FM_NONE;
    end
  end

  // ==========================================================
  // decode result pipeline
  // ==========================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid_q <= 1'b0;
      dec_op_q <= `OOD_OP_UNDEF;
      dec_form_q <= `OOD_FM_NONE;
      dec_undef_q <= 1'b0;
      dec_range_err_q <= 1'b0;
      dst_addr_q <= 8'h00;
      src_addr_q <= 8'h00;
      dst_ind_q <= 1'b0;
      src_ind_q <= 1'b0;
      branch_taken_q <= 1'b0;
      branch_target_q <= {ADDR_W{1'b0}};
      undef_cnt_q <= 8'h00;
    end else begin
      dec_valid_q <= op_valid & ctrl_q[0];
      if (op_valid && ctrl_q[0]) begin
        dec_op_q <= op_d;
        dec_form_q <= form_d;
        dec_undef_q <= undef_d;
        dec_range_err_q <= err_d;
        dst_addr_q <= dst_d;
        src_addr_q <= src_d;
        dst_ind_q <= dind_d;
        src_ind_q <= sind_d;
        branch_taken_q <= br_d;
        branch_target_q <= tgt_d;
        if (undef_d && undef_cnt_q != 8'hff)
          undef_cnt_q <= undef_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  // ==========================================================
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  reg hit;
  reg [31:0] rdata_d;
  always @* begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `OOD_FLAGS_OFF: rdata_d = {24'h00_0000, flags_q};
      `OOD_CTRL_OFF: rdata_d = {16'h0000, wpage_q, ctrl_q};
      `OOD_OPND_OFF: rdata_d = {21'h00_0000, ck_kind_q, ck_val_q};
      `OOD_STAT_OFF: rdata_d = {23'h00_0000, ck_ok_q, undef_cnt_q};
      `OOD_RESULT_OFF: rdata_d = {{(32-ADDR_W){1'b0}}, idx_addr_q};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `OOD_FLAGS_RST;
      ctrl_q <= `OOD_CTRL_RST;
      wpage_q <= 8'h00;
      ck_kind_q <= `OOD_CK_WREG;
      ck_val_q <= 8'h00;
      ck_ok_q <= 1'b1;
      idx_addr_q <= {ADDR_W{1'b0}};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ck_ok_q <= ck_ok_d;
      idx_addr_q <= idx_addr_d;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_en)
        prdata <= rdata_d;
      if (wr_en && hit) begin
        case (paddr)
          `OOD_FLAGS_OFF: flags_q <= pwdata[7:0];
          `OOD_CTRL_OFF: begin
            ctrl_q <= pwdata[7:0];
            wpage_q <= pwdata[15:8];
          end
          `OOD_OPND_OFF: begin
            ck_val_q <= pwdata[7:0];
            ck_kind_q <= pwdata[10:8];
          end
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end
endmodule // ood_decoder
`default_nettype wire

/* File: shared/ood_map.vh */
`ifndef OOD_MAP_VH
`define OOD_MAP_VH
// register byte addresses on apb, one aligned word each
// flags keeps its printed index; byte address is four times it
`define OOD_FLAGS_IDX 8'hd5
`define OOD_FLAGS_OFF 10'h354
`define OOD_CTRL_OFF 10'h000
`define OOD_RESULT_OFF 10'h004
`define OOD_OPND_OFF 10'h008
`define OOD_STAT_OFF 10'h00c
`define OOD_PC_OFF 10'h010
// flag bit positions
`define OOD_FLAG_V 4
`define OOD_FLAG_S 5
`define OOD_FLAG_Z 6
`define OOD_FLAG_C 7
// reset values
`define OOD_FLAGS_RST 8'h00
`define OOD_CTRL_RST 8'h00
// operation codes
`define OOD_OP_UNDEF 5'h00
`define OOD_OP_ADD 5'h01
`define OOD_OP_ADC 5'h02
`define OOD_OP_SUB 5'h03
`define OOD_OP_SUBTRACT_BORROW 5'h04
`define OOD_OP_OR 5'h05
`define OOD_OP_AND 5'h06
`define OOD_OP_TEST_COMPLEMENT_MASK 5'h07
`define OOD_OP_TEST_MASK 5'h08
`define OOD_OP_COMPARE 5'h09
`define OOD_OP_XOR 5'h0a
`define OOD_OP_IDLE 5'h0b
`define OOD_OP_STOP 5'h0c
`define OOD_OP_DISABLE_INTERRUPTS 5'h0d
`define OOD_OP_ENABLE_INTERRUPTS 5'h0e
`define OOD_OP_RET 5'h0f
`define OOD_OP_INTERRUPT_RETURN 5'h10
`define OOD_OP_RESET_CARRY 5'h11
`define OOD_OP_SET_CARRY 5'h12
`define OOD_OP_COMPLEMENT_CARRY 5'h13
`define OOD_OP_NOP 5'h14
`define OOD_OP_JR 5'h15
`define OOD_OP_JP 5'h16
// operand forms
`define OOD_FM_NONE 3'h0
`define OOD_FM_RR 3'h1
`define OOD_FM_RIR 3'h2
`define OOD_FM_GG 3'h3
`define OOD_FM_GIG 3'h4
`define OOD_FM_GIM 3'h5
`define OOD_FM_REL 3'h6
`define OOD_FM_DA 3'h7
// operand check kinds
`define OOD_CK_WREG 3'h0
`define OOD_CK_GREG 3'h1
`define OOD_CK_PAIR 3'h2
`define OOD_CK_IPAIR 3'h3
`define OOD_CK_SIDX 3'h4
`define OOD_CK_LIDX 3'h5
`define OOD_CK_REL 3'h6
`define OOD_CK_IWREG 3'h7
// working register page marker in 8-bit operand
`define OOD_WREG_TAG 4'hc
`endif
